// [lrsd_cfg_regs.sv]
`timescale 1ns/1ps
module lrsd_cfg_regs
    import lrsd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration access
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Decoded controls
    output lrsd_pkg::lrsd_ctl_t ctl
);
    wire hit_hole = cfg_addr == LRSD_OFF_FIXED_HOLE_CONTROL;
    wire hit_smm = cfg_addr == LRSD_OFF_SMM_RAM_CONTROL;
    wire wr_hole = cfg_write && hit_hole;
    wire wr_smm = cfg_write && hit_smm;
    wire wd_lock = cfg_wdata[LRSD_BIT_SMM_LOCK];
    wire wd_enable = cfg_wdata[LRSD_BIT_SMM_GLOBAL_ENABLE];
    // Lock arms only with the enable already set or written set; the same write can still clear the enable
    wire next_lock = wd_lock && (ctl.smm_global_enable || wd_enable);
    wire [7:0] smm_value = {1'b0, ctl.smm_open, ctl.smm_close, ctl.smm_lock,
                            ctl.smm_global_enable, LRSD_SMM_BASE_SEGMENT};
    wire [7:0] hole_value = {ctl.hole_enable, 7'h00};
    wire [7:0] next_rdata = hit_hole ? hole_value : (hit_smm ? smm_value : 8'h00);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl <= '0;
            cfg_rdata <= 8'h00;
        end else begin
            if (cfg_read) begin
                cfg_rdata <= next_rdata;
            end
            if (wr_hole) begin
                ctl.hole_enable <= cfg_wdata[LRSD_BIT_HOLE_ENABLE];
            end
            if (wr_smm) begin
                ctl.smm_close <= cfg_wdata[LRSD_BIT_SMM_CLOSE];
                if (!ctl.smm_lock) begin
                    ctl.smm_global_enable <= wd_enable;
                    ctl.smm_lock <= next_lock;
                    ctl.smm_open <= next_lock ? 1'b0 : cfg_wdata[LRSD_BIT_SMM_OPEN];
                end
            end
        end
    end

    a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
        ctl.smm_lock |=> ctl.smm_lock)
        else $error("lock bit cleared without reset");
    a_lock_freezes: assert property (@(posedge clk) disable iff (rst)
        ctl.smm_lock |=> $stable(ctl.smm_global_enable) && !ctl.smm_open)
        else $error("locked control changed");
endmodule

// [lrsd_decoder.sv]
`timescale 1ns/1ps
module lrsd_decoder
    import lrsd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration access
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Controls held outside this block
    input wire logic dos_hole_select,
    input wire logic vga_to_graphics,
    input wire lrsd_pkg::lrsd_seg_attr_t [LRSD_NUM_SEGS-1:0] shadow_attribute_map,
    // Host processor cycles
    input wire lrsd_pkg::lrsd_host_req_t host_req,
    output logic host_route_valid,
    output lrsd_pkg::lrsd_route_t host_route,
    // Hub and graphics initiated cycles
    input wire lrsd_pkg::lrsd_in_req_t in_req,
    output logic in_done,
    output logic in_claim
);
    import lrsd_pkg::*;

    lrsd_ctl_t ctl;
    lrsd_seg_attr_t seg_attr;

    lrsd_cfg_regs u_regs (
        .clk(clk),
        .rst(rst),
        .cfg_write(cfg_write),
        .cfg_read(cfg_read),
        .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .ctl(ctl)
    );

    lrsd_shadow_lookup #(
        .NUM_SMALL(LRSD_NUM_SMALL_SEGS)
    ) u_shadow (
        .addr(host_req.addr),
        .attr(shadow_attribute_map),
        .seg_attr(seg_attr)
    );

    // Host address classes
    wire [31:0] ha = host_req.addr;
    wire h_dos_low = ha <= LRSD_DOS_LOW_LIMIT;
    wire h_dos_high = ha >= LRSD_DOS_HIGH_BASE && ha <= LRSD_DOS_HIGH_LIMIT;
    wire h_video = ha >= LRSD_VIDEO_BASE && ha <= LRSD_VIDEO_LIMIT;
    wire h_shadow = ha >= LRSD_SHADOW_BASE && ha <= LRSD_LEGACY_LIMIT;
    wire h_hole = ha >= LRSD_HOLE_BASE && ha <= LRSD_HOLE_LIMIT;

    // Open, close and lock gated by the global enable
    wire smm_enabled = ctl.smm_global_enable;
    wire eff_open = smm_enabled && ctl.smm_open && !ctl.smm_lock;
    wire eff_close = smm_enabled && ctl.smm_close;
    wire smm_decode_ok = host_req.smm && !(eff_close && !host_req.code);
    wire smm_visible = smm_enabled && (smm_decode_ok || eff_open);

    // Video range never remapped; failed visibility goes out by VGA control
    wire lrsd_route_t video_out = vga_to_graphics ? LRSD_TO_GRAPHICS
                                                  : LRSD_TO_LEGACY_PCI;
    wire lrsd_route_t video_route = smm_visible ? LRSD_TO_MEMORY : video_out;
    wire seg_enable = host_req.write ? seg_attr.write_route_enable
                                     : seg_attr.read_route_enable;
    wire lrsd_route_t shadow_route = seg_enable ? LRSD_TO_MEMORY
                                                : LRSD_TO_LEGACY_PCI;
    wire lrsd_route_t dos_route = dos_hole_select ? LRSD_TO_LEGACY_PCI
                                                  : LRSD_TO_MEMORY;
    wire lrsd_route_t hole_route = ctl.hole_enable ? LRSD_TO_LEGACY_PCI
                                                   : LRSD_TO_MEMORY;

    lrsd_route_t next_host_route;
    always_comb begin
        if (h_dos_low) begin
            next_host_route = LRSD_TO_MEMORY;
        end else if (h_dos_high) begin
            next_host_route = dos_route;
        end else if (h_video) begin
            next_host_route = video_route;
        end else if (h_shadow) begin
            next_host_route = shadow_route;
        end else if (h_hole) begin
            next_host_route = hole_route;
        end else begin
            next_host_route = LRSD_TO_MEMORY;
        end
    end

    // Inbound cycles: refused in SMM video space, and in an enabled hole unless from graphics
    wire [31:0] ia = in_req.addr;
    wire i_video = ia >= LRSD_VIDEO_BASE && ia <= LRSD_VIDEO_LIMIT;
    wire i_hole = ia >= LRSD_HOLE_BASE && ia <= LRSD_HOLE_LIMIT;
    wire i_smm_block = i_video && smm_enabled;
    wire i_hole_block = i_hole && ctl.hole_enable && !in_req.from_graphics;
    wire next_in_claim = !(i_smm_block || i_hole_block);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_route_valid <= 1'b0;
            host_route <= LRSD_TO_MEMORY;
            in_done <= 1'b0;
            in_claim <= 1'b0;
        end else begin
            host_route_valid <= host_req.valid;
            in_done <= in_req.valid;
            if (host_req.valid) begin
                host_route <= next_host_route;
            end
            in_claim <= in_req.valid && next_in_claim;
        end
    end

    // Read strobe aimed at the SMM control register, for the lock check
    wire rd_smm_reg = cfg_read && cfg_addr == LRSD_OFF_SMM_RAM_CONTROL;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_low_dos_memory: assert property (
        host_req.valid && h_dos_low |=> host_route_valid && host_route == LRSD_TO_MEMORY)
        else $error("low DOS area not routed to memory");
    a_dos_hole_route: assert property (
        host_req.valid && h_dos_high |=>
        host_route == ($past(dos_hole_select) ? LRSD_TO_LEGACY_PCI : LRSD_TO_MEMORY))
        else $error("upper DOS area misrouted");
    a_video_no_smm: assert property (
        host_req.valid && h_video && !ctl.smm_global_enable |=>
        host_route == ($past(vga_to_graphics) ? LRSD_TO_GRAPHICS : LRSD_TO_LEGACY_PCI))
        else $error("video cycle without SMM reached memory");
    a_smm_visible: assert property (
        host_req.valid && h_video && ctl.smm_global_enable && host_req.smm &&
        (host_req.code || !ctl.smm_close) |=> host_route == LRSD_TO_MEMORY)
        else $error("SMM cycle did not reach SMM memory");
    a_close_data: assert property (
        host_req.valid && h_video && ctl.smm_global_enable && ctl.smm_close &&
        !host_req.code && !(ctl.smm_open && !ctl.smm_lock) |=>
        host_route != LRSD_TO_MEMORY)
        else $error("closed SMM space served a data reference");
    a_open_visible: assert property (
        host_req.valid && h_video && ctl.smm_global_enable && ctl.smm_open &&
        !ctl.smm_lock |=> host_route == LRSD_TO_MEMORY)
        else $error("open SMM space not visible");
    a_hole_host: assert property (
        host_req.valid && h_hole && ctl.hole_enable |=>
        host_route == LRSD_TO_LEGACY_PCI)
        else $error("host hole cycle not forwarded");
    a_hole_inbound: assert property (
        in_req.valid && i_hole && ctl.hole_enable && !in_req.from_graphics |=>
        in_done && !in_claim)
        else $error("hub cycle in hole claimed");
    a_smm_inbound: assert property (
        in_req.valid && i_video && ctl.smm_global_enable |=> !in_claim)
        else $error("inbound cycle reached SMM space");
    a_shadow_read: assert property (
        host_req.valid && h_shadow && !host_req.write |=>
        host_route == ($past(seg_attr.read_route_enable) ? LRSD_TO_MEMORY
                                                         : LRSD_TO_LEGACY_PCI))
        else $error("shadow read misrouted");
    a_lock_clears_open: assert property (
        cfg_write && cfg_addr == LRSD_OFF_SMM_RAM_CONTROL && !ctl.smm_lock &&
        cfg_wdata[LRSD_BIT_SMM_LOCK] && cfg_wdata[LRSD_BIT_SMM_GLOBAL_ENABLE] |=>
        ctl.smm_lock && !ctl.smm_open ##1 (cfg_rdata[2:0] == LRSD_SMM_BASE_SEGMENT
        || !$past(rd_smm_reg)))
        else $error("lock write did not clear open");
endmodule

// [lrsd_decoder_tb.sv]
`timescale 1ns/1ps
module lrsd_decoder_tb;
    import lrsd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_write = 1'b0;
    logic cfg_read = 1'b0;
    logic [7:0] cfg_addr = 8'h0;
    logic [7:0] cfg_wdata = 8'h0;
    logic [7:0] cfg_rdata;
    logic dos_hole_select = 1'b0;
    logic vga_to_graphics = 1'b0;
    lrsd_seg_attr_t [LRSD_NUM_SEGS-1:0] map = '0;
    logic host_go = 1'b0;
    logic in_go = 1'b0;
    lrsd_host_req_t host_cmd = '0;
    lrsd_in_req_t in_cmd = '0;
    lrsd_host_req_t host_req;
    lrsd_in_req_t in_req;
    logic host_route_valid;
    lrsd_route_t host_route;
    logic in_done;
    logic in_claim;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    lrsd_far_model far (.clk(clk), .host_go(host_go), .host_cmd(host_cmd), .in_go(in_go),
        .in_cmd(in_cmd), .host_req(host_req), .in_req(in_req));
    lrsd_decoder dut (.clk(clk), .rst(rst), .cfg_write(cfg_write), .cfg_read(cfg_read),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .dos_hole_select(dos_hole_select), .vga_to_graphics(vga_to_graphics),
        .shadow_attribute_map(map), .host_req(host_req), .host_route_valid(host_route_valid),
        .host_route(host_route), .in_req(in_req), .in_done(in_done), .in_claim(in_claim));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic test_done();
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic chk_route(input string n, input lrsd_route_t e, input lrsd_route_t g);
        checked++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_write = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_write = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cfg_read = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_read = 1'b0;
        chk_reg("cfg_rdata", e, cfg_rdata);
        @(negedge clk);
    endtask

    task automatic host(input logic [31:0] a, input logic w, s, c, input lrsd_route_t e);
        host_cmd = {1'b1, a, w, s, c};
        host_go = 1'b1;
        @(negedge clk);
        host_go = 1'b0;
        chk_reg("host_route_valid", 8'h1, {7'h0, host_route_valid});
        chk_route("host_route", e, host_route);
        @(negedge clk);
    endtask

    task automatic inb(input logic [31:0] a, input logic g, input logic e);
        in_cmd = {1'b1, a, g};
        in_go = 1'b1;
        @(negedge clk);
        in_go = 1'b0;
        chk_reg("in_done", 8'h1, {7'h0, in_done});
        chk_reg("in_claim", {7'h0, e}, {7'h0, in_claim});
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        logic [31:0] base;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(8'h9D, 8'h02);
        rd(8'h97, 8'h00);
        rd(8'h98, 8'h00);
        wr(8'h97, 8'hFF);
        rd(8'h97, 8'h80);
        wr(8'h9D, 8'hC5);
        rd(8'h9D, 8'h42);
        wr(8'h9D, 8'h00);
        wr(8'h97, 8'h00);
        dos_hole_select = 1'b1;
        host(32'h7FFFF, 1'b0, 1'b0, 1'b0, LRSD_TO_MEMORY);
        host(32'h80000, 1'b0, 1'b0, 1'b0, LRSD_TO_LEGACY_PCI);
        dos_hole_select = 1'b0;
        host(32'h9FFFF, 1'b1, 1'b0, 1'b0, LRSD_TO_MEMORY);
        host(32'hA0000, 1'b0, 1'b1, 1'b0, LRSD_TO_LEGACY_PCI);
        vga_to_graphics = 1'b1;
        host(32'hBFFFF, 1'b1, 1'b0, 1'b0, LRSD_TO_GRAPHICS);
        vga_to_graphics = 1'b0;
        for (int i = 0; i < LRSD_NUM_SEGS; i++) begin
            map = {LRSD_NUM_SEGS{2'h2}};
            map[i] = 2'h1;
            base = (i < 12) ? 32'hC0000 + i * 32'h4000 : 32'hF0000;
            host(base, 1'b0, 1'b0, 1'b0, LRSD_TO_MEMORY);
            host(base + ((i < 12) ? 32'h3FFF : 32'hFFFF), 1'b1, 1'b0, 1'b0,
                LRSD_TO_LEGACY_PCI);
        end
        host(32'hA0000, 1'b1, 1'b0, 1'b0, LRSD_TO_LEGACY_PCI);
        wr(8'h97, 8'h80);
        host(32'hF00000, 1'b0, 1'b0, 1'b0, LRSD_TO_LEGACY_PCI);
        host(32'hEFFFFF, 1'b0, 1'b0, 1'b0, LRSD_TO_MEMORY);
        host(32'h1000000, 1'b0, 1'b0, 1'b0, LRSD_TO_MEMORY);
        inb(32'hF00000, 1'b0, 1'b0);
        inb(32'hFFFFFF, 1'b1, 1'b1);
        wr(8'h97, 8'h00);
        inb(32'hF00000, 1'b0, 1'b1);
        wr(8'h9D, 8'h40);
        host(32'hA0000, 1'b0, 1'b0, 1'b0, LRSD_TO_LEGACY_PCI);
        wr(8'h9D, 8'h0A);
        host(32'hA0000, 1'b0, 1'b1, 1'b0, LRSD_TO_MEMORY);
        host(32'hBFFFF, 1'b0, 1'b0, 1'b0, LRSD_TO_LEGACY_PCI);
        inb(32'hA0000, 1'b0, 1'b0);
        inb(32'hA0000, 1'b1, 1'b0);
        inb(32'hC0000, 1'b0, 1'b1);
        wr(8'h9D, 8'h2A);
        host(32'hA0000, 1'b0, 1'b1, 1'b0, LRSD_TO_LEGACY_PCI);
        host(32'hA0000, 1'b0, 1'b1, 1'b1, LRSD_TO_MEMORY);
        wr(8'h9D, 8'h4A);
        host(32'hB0000, 1'b1, 1'b0, 1'b0, LRSD_TO_MEMORY);
        wr(8'h9D, 8'h1A);
        rd(8'h9D, 8'h1A);
        host(32'hB0000, 1'b1, 1'b0, 1'b0, LRSD_TO_LEGACY_PCI);
        wr(8'h9D, 8'h42);
        rd(8'h9D, 8'h1A);
        wr(8'h9D, 8'h3A);
        rd(8'h9D, 8'h3A);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(8'h9D, 8'h02);
        test_done();
    end
endmodule

// [lrsd_far_model.sv]
`timescale 1ns/1ps
module lrsd_far_model
    import lrsd_pkg::*;
(
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic host_go,
    input wire lrsd_pkg::lrsd_host_req_t host_cmd,
    input wire logic in_go,
    input wire lrsd_pkg::lrsd_in_req_t in_cmd,
    // Requests toward the decoder
    output lrsd_pkg::lrsd_host_req_t host_req,
    output lrsd_pkg::lrsd_in_req_t in_req
);
    logic [31:0] last_addr = 32'h0;
    // Idle buses show the inverted last address, never a stale copy
    assign host_req = host_go ? {1'b1, host_cmd.addr, host_cmd.write, host_cmd.smm, host_cmd.code}
                              : {1'b0, ~last_addr, 3'h0};
    assign in_req = in_go ? {1'b1, in_cmd.addr, in_cmd.from_graphics} : {1'b0, ~last_addr, 1'b0};
    always_ff @(posedge clk) begin
        if (host_go || in_go) begin
            last_addr <= host_go ? host_cmd.addr : in_cmd.addr;
        end
    end
endmodule

// [lrsd_pkg.sv]
package lrsd_pkg;

    // Configuration register offsets and reset values
    localparam logic [7:0] LRSD_OFF_FIXED_HOLE_CONTROL = 8'h97;
    localparam logic [7:0] LRSD_OFF_SMM_RAM_CONTROL = 8'h9D;
    localparam logic [7:0] LRSD_RST_FIXED_HOLE_CONTROL = 8'h00;
    localparam logic [7:0] LRSD_RST_SMM_RAM_CONTROL = 8'h02;

    // Field positions
    localparam int LRSD_BIT_HOLE_ENABLE = 7;
    localparam int LRSD_BIT_SMM_OPEN = 6;
    localparam int LRSD_BIT_SMM_CLOSE = 5;
    localparam int LRSD_BIT_SMM_LOCK = 4;
    localparam int LRSD_BIT_SMM_GLOBAL_ENABLE = 3;
    localparam logic [2:0] LRSD_SMM_BASE_SEGMENT = 3'h2;

    // Address map, in host address bits
    localparam logic [31:0] LRSD_DOS_LOW_LIMIT = 32'h0007_FFFF;
    localparam logic [31:0] LRSD_DOS_HIGH_BASE = 32'h0008_0000;
    localparam logic [31:0] LRSD_DOS_HIGH_LIMIT = 32'h0009_FFFF;
    localparam logic [31:0] LRSD_VIDEO_BASE = 32'h000A_0000;
    localparam logic [31:0] LRSD_VIDEO_LIMIT = 32'h000B_FFFF;
    localparam logic [31:0] LRSD_SHADOW_BASE = 32'h000C_0000;
    localparam logic [31:0] LRSD_LEGACY_LIMIT = 32'h000F_FFFF;
    localparam logic [31:0] LRSD_HOLE_BASE = 32'h00F0_0000;
    localparam logic [31:0] LRSD_HOLE_LIMIT = 32'h00FF_FFFF;

    // Shadow segments: twelve 16 KB pieces from C0000h, then one 64 KB piece
    localparam int LRSD_NUM_SMALL_SEGS = 12;
    localparam int LRSD_NUM_SEGS = 13;
    localparam logic [5:0] LRSD_FIRST_SEG_INDEX = 6'h30;
    localparam logic [3:0] LRSD_TOP_SEG_INDEX = 4'hF;

    typedef enum logic [1:0] {
        LRSD_TO_MEMORY = 2'h0,
        LRSD_TO_LEGACY_PCI = 2'h1,
        LRSD_TO_GRAPHICS = 2'h2
    } lrsd_route_t;

    typedef struct packed {
        logic write_route_enable;
        logic read_route_enable;
    } lrsd_seg_attr_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic smm;
        logic code;
    } lrsd_host_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic from_graphics;
    } lrsd_in_req_t;

    typedef struct packed {
        logic hole_enable;
        logic smm_open;
        logic smm_close;
        logic smm_lock;
        logic smm_global_enable;
    } lrsd_ctl_t;

endpackage

// [lrsd_shadow_lookup.sv]
`timescale 1ns/1ps
module lrsd_shadow_lookup
    import lrsd_pkg::*;
#(
    parameter int NUM_SMALL = LRSD_NUM_SMALL_SEGS
) (
    // Host address and segment attributes
    input wire logic [31:0] addr,
    input wire lrsd_pkg::lrsd_seg_attr_t [NUM_SMALL:0] attr,
    // Attributes of the segment hit
    output lrsd_pkg::lrsd_seg_attr_t seg_attr
);
    logic [NUM_SMALL:0] seg_hit;
    wire in_legacy = addr[31:20] == 12'h000;

    genvar i;
    generate
        for (i = 0; i < NUM_SMALL; i++) begin : g_seg
            // One 16 KB segment each
            assign seg_hit[i] = in_legacy &&
                addr[19:14] == LRSD_FIRST_SEG_INDEX + 6'(i);
        end
    endgenerate
    // Whole 64 KB top piece shares one attribute pair
    assign seg_hit[NUM_SMALL] = in_legacy && addr[19:16] == LRSD_TOP_SEG_INDEX;

    always_comb begin
        seg_attr = '0;
        for (int k = 0; k <= NUM_SMALL; k++) begin
            if (seg_hit[k]) begin
                seg_attr = attr[k];
            end
        end
    end
endmodule
